// [rtl/asq_pkg.sv]
package asq_pkg;

    // ****************************************************************
    // Register map (byte addresses, one aligned word each)
    // ****************************************************************
    localparam logic [7:0] OFS_CTRL_ONE  = 8'h00;
    localparam logic [7:0] OFS_CTRL_TWO  = 8'h04;
    localparam logic [7:0] OFS_CTRL_THREE = 8'h08;
    localparam logic [7:0] OFS_AUX_SEL   = 8'h0C;
    localparam logic [7:0] OFS_LEAD_SEL  = 8'h10;
    localparam logic [7:0] OFS_STATUS    = 8'h14;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int C1_ON_BIT      = 15;
    localparam int C1_TWELVE_BIT  = 10;
    localparam int C1_TRIG_LSB    = 5;
    localparam int C1_AUTO_BIT    = 2;
    localparam int C1_ACQ_BIT     = 1;
    localparam int C1_DONE_BIT    = 0;
    localparam int C2_REF_LSB     = 13;
    localparam int C2_SCAN_BIT    = 10;
    localparam int C2_CNT_LSB     = 8;
    localparam int C2_HALF_BIT    = 7;
    localparam int C2_SPI_LSB     = 2;
    localparam int C2_SPLIT_BIT   = 1;
    localparam int C2_ALT_BIT     = 0;
    localparam int C3_RC_BIT      = 15;
    localparam int C3_TIME_LSB    = 8;

    // Writable masks; unimplemented bits read as zero
    localparam logic [15:0] C1_WMASK  = 16'hA7E6;
    localparam logic [15:0] C2_WMASK  = 16'hE73F;
    localparam logic [15:0] C3_WMASK  = 16'h9F3F;
    localparam logic [15:0] AUX_WMASK = 16'h0707;
    localparam logic [15:0] LEAD_WMASK = 16'h9F9F;
    localparam logic [15:0] REG_RESET = 16'h0000;

    // Conversion length in conversion clock periods (plain default)
    localparam logic [4:0]  CONV_TADS = 5'h0C;
    localparam logic [2:0]  TRIG_SOFT = 3'h0;
    localparam logic [2:0]  TRIG_AUTO = 3'h7;

    // Analog routing selection carried to the converter core
    typedef struct packed {
        logic [2:0] reference;
        logic [4:0] lead_pos;
        logic       lead_neg;
        logic [1:0] aux_neg;
        logic       aux_pos;
        logic [1:0] channels;
        logic       rc_clock;
    } asq_route_t;

endpackage

// [rtl/asq_top.sv]
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// (RULE1) Auto start set: sampling restarts after conversion and acquire bit self-sets.
// (RULE2) Acquire bit reads one while sampling, zero while holding.
// (RULE3) Trigger 000: software clearing acquire bit starts conversion.
// (RULE4) Other triggers: hardware clears acquire bit on trigger and converts; code 100 here never fires.
// (RULE5) Done bit set when conversion finishes; zero otherwise.
// (RULE6) Software may only clear done; clearing never disturbs conversion.
// (RULE7) Done bit cleared by hardware at each conversion start.
// (RULE8) Reference select: 001 ext pos, 010 ext neg, 011 both, else internal.
// (RULE9) Scan enable steps channel 0 positive input during Sample A.
// (RULE10) Channel count 1x four channels, 01 two, 00 one.
// (RULE11) Twelve-bit mode: channel count reads zero, one channel only.
// (RULE12) Fill-half flag shows which buffer half is being filled.
// (RULE13) Interrupt after every (N+1)th sequence.
// (RULE14) Split fill alternates halves per interrupt, else restart at zero.
// (RULE15) Alternate toggle swaps Sample A and B selects each sample.
// (RULE16) Clock select bit picks RC oscillator or system-derived clock.
// (RULE17) Auto sample time counts in conversion clock periods, 0 to 31.
// (RULE18) Conversion clock period is instruction cycle times divider plus one.
// (RULE19) Aux negative codes 00/01 pick negative reference; others reserved.
// (RULE20) Aux positive select picks input group 0-2 or 3-5.
// (RULE21) Lead negative select: one input 1, zero negative reference.
// (RULE22) Lead positive select gives the input number directly.
// (RULE23) Trigger 111: internal counter ends sampling after auto time.
// (RULE24) Software turns converter off before changing twelve-bit mode.
// (RULE25) Converter on bit enables module; off holds it idle.
// (RULE26) Interrupt flag at sequence-count completion, then count restarts.
module asq_top
(
    input  wire logic                 clock_in,
    input  wire logic                 arst_n_in,
    input  wire logic                 clk_en_in,
    input  wire logic                 psel_in,
    input  wire logic                 penable_in,
    input  wire logic                 pwrite_in,
    input  wire logic [7:0]           paddr_in,
    input  wire logic [31:0]          pwdata_in,
    input  wire logic [2:0]           ext_trigger_in,
    input  wire logic                 rc_tick_in,
    input  wire logic [5:0]           scan_inputs_in,
    output logic      [31:0]          prdata_out,
    output logic                      pready_out,
    output logic                      pslverr_out,
    output logic                      sampling_out,
    output logic                      convert_out,
    output logic                      sample_b_out,
    output logic      [3:0]           buf_index_out,
    output logic                      seq_irq_out,
    output asq_pkg::asq_route_t       route_out
);
    import asq_pkg::*;

    // ****************************************************************
    // Reset release
    // ****************************************************************
    logic rst_meta_ff;
    logic rst_n_ff;

    // Two stages so release never races the clock
    always_ff @(posedge clock_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            rst_meta_ff <= 1'b0;
            rst_n_ff    <= 1'b0;
        end
        else
        begin
            rst_meta_ff <= 1'b1;
            rst_n_ff    <= rst_meta_ff;
        end
    end

    // ****************************************************************
    // Declarations
    // ****************************************************************
    typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT} asq_state_t;

    asq_state_t  state_ff;
    asq_state_t  nxt_state;
    logic [15:0] ctrl1_ff;
    logic [15:0] ctrl2_ff;
    logic [15:0] ctrl3_ff;
    logic [15:0] aux_ff;
    logic [15:0] lead_ff;
    logic        done_ff;
    logic        half_ff;
    logic        alt_b_ff;
    logic [3:0]  seq_cnt_ff;
    logic [3:0]  buf_idx_ff;
    logic [2:0]  scan_pos_ff;
    logic [5:0]  div_cnt_ff;
    logic        tad_tick_ff;
    logic [4:0]  tad_cnt_ff;
    logic [31:0] prdata_ff;
    logic        pready_ff;
    logic        irq_ff;

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    function automatic logic [15:0] merge(input logic [15:0] old,
                                         input logic [31:0] wd,
                                         input logic [15:0] msk);
        merge = (old & ~msk) | (wd[15:0] & msk);
    endfunction

    wire bus_setup  = psel_in && !penable_in;
    // Writes land in the access cycle, at the edge where ready is seen
    wire bus_access = psel_in && penable_in && pready_ff;
    wire wr_c1      = bus_access && pwrite_in && (paddr_in == OFS_CTRL_ONE);
    wire wr_c2      = bus_access && pwrite_in && (paddr_in == OFS_CTRL_TWO);
    wire wr_c3      = bus_access && pwrite_in && (paddr_in == OFS_CTRL_THREE);
    wire wr_aux     = bus_access && pwrite_in && (paddr_in == OFS_AUX_SEL);
    wire wr_lead    = bus_access && pwrite_in && (paddr_in == OFS_LEAD_SEL);
    wire mapped     = (paddr_in <= OFS_STATUS) && (paddr_in[1:0] == 2'b00);

    // Field views
    wire        conv_on   = ctrl1_ff[C1_ON_BIT];
    wire        twelve    = ctrl1_ff[C1_TWELVE_BIT];
    wire [2:0]  trig_sel  = ctrl1_ff[C1_TRIG_LSB +: 3];
    wire        auto_acq  = ctrl1_ff[C1_AUTO_BIT];
    wire        scan_en   = ctrl2_ff[C2_SCAN_BIT];
    wire [1:0]  chan_cnt  = twelve ? 2'b00 : ctrl2_ff[C2_CNT_LSB +: 2];     // RULE11
    wire [3:0]  seq_per   = ctrl2_ff[C2_SPI_LSB +: 4];
    wire        split     = ctrl2_ff[C2_SPLIT_BIT];
    wire        alt_on    = ctrl2_ff[C2_ALT_BIT];
    wire [4:0]  acq_time  = ctrl3_ff[C3_TIME_LSB +: 5];
    wire [5:0]  tad_div   = ctrl3_ff[5:0];

    // Acquire bit as software writes it
    wire        sw_acq_set = wr_c1 && pwdata_in[C1_ACQ_BIT] && !auto_acq;
    wire        sw_acq_end = wr_c1 && !pwdata_in[C1_ACQ_BIT] && (trig_sel == TRIG_SOFT);
    wire        sw_done_clr = wr_c1 && !pwdata_in[C1_DONE_BIT];

    // Conversion clock tick from system or RC source
    wire        tad_tick  = ctrl3_ff[C3_RC_BIT] ? rc_tick_in : tad_tick_ff; // RULE16

    // Trigger decode: software, external or auto counter
    wire        auto_end  = (trig_sel == TRIG_AUTO) && tad_tick
                            && (tad_cnt_ff >= acq_time);                    // RULE23
    // Code 100 would index past the three trigger lines, so it never fires
    wire        ext_end   = (trig_sel != TRIG_SOFT) && (trig_sel != TRIG_AUTO)
                            && (trig_sel[1:0] != 2'b00)
                            && ext_trigger_in[trig_sel[1:0] - 2'd1];
    wire        acq_end   = (state_ff == ST_SAMPLE)
                            && (sw_acq_end || auto_end || ext_end);         // RULE3 RULE4
    wire        conv_fin  = (state_ff == ST_CONVERT) && tad_tick
                            && (tad_cnt_ff == CONV_TADS);
    wire        seq_last  = conv_fin && (seq_cnt_ff == seq_per);            // RULE13

    // ****************************************************************
    // Sequencer next state
    // ****************************************************************
    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE:
                if (conv_on && (auto_acq || sw_acq_set))                    // RULE1
                    nxt_state = ST_SAMPLE;
            ST_SAMPLE:
                if (acq_end)
                    nxt_state = ST_CONVERT;
            ST_CONVERT:
                if (conv_fin)
                    nxt_state = auto_acq ? ST_SAMPLE : ST_IDLE;             // RULE1
            default:
                nxt_state = ST_IDLE;
        endcase
        if (!conv_on)
            nxt_state = ST_IDLE;                                            // RULE25
    end

    // ****************************************************************
    // Registers written by software
    // ****************************************************************
    // Twelve-bit mode only changes while off, software keeps that order
    always_ff @(posedge clock_in or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
        begin
            ctrl1_ff <= REG_RESET;
            ctrl2_ff <= REG_RESET;
            ctrl3_ff <= REG_RESET;
            aux_ff   <= REG_RESET;
            lead_ff  <= REG_RESET;
        end
        else if (clk_en_in)
        begin
            if (wr_c1)
                ctrl1_ff <= merge(ctrl1_ff, pwdata_in, C1_WMASK);           // RULE24
            if (wr_c2)
                ctrl2_ff <= merge(ctrl2_ff, pwdata_in, C2_WMASK);
            if (wr_c3)
                ctrl3_ff <= merge(ctrl3_ff, pwdata_in, C3_WMASK);
            if (wr_aux)
                aux_ff <= merge(aux_ff, pwdata_in, AUX_WMASK);
            if (wr_lead)
                lead_ff <= merge(lead_ff, pwdata_in, LEAD_WMASK);
        end
    end

    // ****************************************************************
    // Clock divider and period counter
    // ****************************************************************
    // Divider runs always so the tick stays periodic
    always_ff @(posedge clock_in or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
        begin
            div_cnt_ff  <= 6'h00;
            tad_tick_ff <= 1'b0;
            tad_cnt_ff  <= 5'h00;
        end
        else if (clk_en_in)
        begin
            tad_tick_ff <= (div_cnt_ff >= tad_div);                         // RULE18
            div_cnt_ff  <= (div_cnt_ff >= tad_div) ? 6'h00 : div_cnt_ff + 6'd1;
            if (nxt_state != state_ff)
                tad_cnt_ff <= 5'h00;
            else if (tad_tick && tad_cnt_ff != 5'h1F)
                tad_cnt_ff <= tad_cnt_ff + 5'd1;                            // RULE17
        end
    end

    // ****************************************************************
    // Sequencer state, status and buffer position
    // ****************************************************************
    always_ff @(posedge clock_in or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
        begin
            state_ff    <= ST_IDLE;
            done_ff     <= 1'b0;
            half_ff     <= 1'b0;
            alt_b_ff    <= 1'b0;
            seq_cnt_ff  <= 4'h0;
            buf_idx_ff  <= 4'h0;
            scan_pos_ff <= 3'h0;
            irq_ff      <= 1'b0;
        end
        else if (clk_en_in)
        begin
            state_ff <= nxt_state;
            irq_ff   <= seq_last;                                           // RULE26
            // Hardware set beats software clear
            if (conv_fin)
                done_ff <= 1'b1;                                            // RULE5
            else if (acq_end || sw_done_clr)
                done_ff <= 1'b0;                                            // RULE6 RULE7
            if (conv_fin)
            begin
                alt_b_ff    <= alt_on && !alt_b_ff;                         // RULE15
                // Scan advances on Sample A only and holds across Sample B
                scan_pos_ff <= !scan_en ? 3'h0 : (alt_b_ff ? scan_pos_ff : scan_pos_ff + 3'd1);
                seq_cnt_ff  <= seq_last ? 4'h0 : seq_cnt_ff + 4'd1;         // RULE26
                buf_idx_ff  <= buf_idx_ff + {2'b00, chan_cnt[1] ? 2'd3
                                              : {1'b0, chan_cnt[0]}} + 4'd1;
                if (seq_last)
                begin
                    half_ff    <= split && !half_ff;                        // RULE12 RULE14
                    buf_idx_ff <= (split && !half_ff) ? 4'h8 : 4'h0;        // RULE14
                end
            end
            if (!conv_on)
                seq_cnt_ff <= 4'h0;
        end
    end

    // ****************************************************************
    // Read mux and bus answer
    // ****************************************************************
    wire [15:0] c1_view = (ctrl1_ff & C1_WMASK & ~16'h0003)
                          | {14'h0000, state_ff == ST_SAMPLE, done_ff};     // RULE2
    wire [15:0] c2_view = {ctrl2_ff[15:10], chan_cnt, half_ff, 1'b0,
                           ctrl2_ff[5:0]};
    wire [15:0] rd_mux  = (paddr_in == OFS_CTRL_ONE)   ? c1_view :
                          (paddr_in == OFS_CTRL_TWO)   ? c2_view :
                          (paddr_in == OFS_CTRL_THREE) ? ctrl3_ff :
                          (paddr_in == OFS_AUX_SEL)    ? aux_ff :
                          (paddr_in == OFS_LEAD_SEL)   ? lead_ff :
                          (paddr_in == OFS_STATUS)     ? {12'h000, seq_cnt_ff} : 16'h0000;

    // Answer one cycle after setup: prepared during the setup cycle
    always_ff @(posedge clock_in or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
        begin
            prdata_ff   <= 32'h0000_0000;
            pready_ff   <= 1'b0;
            pslverr_out <= 1'b0;
        end
        else if (clk_en_in)
        begin
            pready_ff   <= bus_setup;
            pslverr_out <= bus_setup && !mapped;
            if (bus_setup && !pwrite_in)
                prdata_ff <= {16'h0000, rd_mux};
        end
    end

    // ****************************************************************
    // Analog routing toward the converter core
    // ****************************************************************
    // Scan takes the input number straight from the scan position, Sample A only
    wire [4:0]  pos_a   = scan_en ? {2'b00, scan_pos_ff} : lead_ff[4:0];    // RULE9 RULE22
    wire        use_b   = alt_on && alt_b_ff;
    asq_route_t nxt_route;
    assign nxt_route.reference = ctrl2_ff[C2_REF_LSB +: 3];                 // RULE8
    assign nxt_route.lead_pos  = use_b ? lead_ff[12:8] : pos_a;             // RULE15
    assign nxt_route.lead_neg  = use_b ? lead_ff[15] : lead_ff[7];          // RULE21
    assign nxt_route.aux_neg   = twelve ? 2'b00 : (use_b ? aux_ff[10:9] : aux_ff[2:1]); // RULE19
    assign nxt_route.aux_pos   = !twelve && (use_b ? aux_ff[8] : aux_ff[0]); // RULE20
    assign nxt_route.channels  = chan_cnt;                                  // RULE10
    assign nxt_route.rc_clock  = ctrl3_ff[C3_RC_BIT];

    // Outputs registered so the core sees glitch-free controls
    always_ff @(posedge clock_in or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
        begin
            sampling_out  <= 1'b0;
            convert_out   <= 1'b0;
            sample_b_out  <= 1'b0;
            buf_index_out <= 4'h0;
            route_out     <= '0;
        end
        else if (clk_en_in)
        begin
            sampling_out  <= (nxt_state == ST_SAMPLE);
            convert_out   <= (nxt_state == ST_CONVERT);
            sample_b_out  <= use_b;
            buf_index_out <= buf_idx_ff;
            route_out     <= nxt_route;
        end
    end

    assign prdata_out  = prdata_ff;
    assign pready_out  = pready_ff;
    assign seq_irq_out = irq_ff;

    // ****************************************************************
    // Checks
    // ****************************************************************
    wire scan_unused = ^scan_inputs_in;

    done_on_finish_a: assert property (@(posedge clock_in) disable iff (!rst_n_ff)
        clk_en_in && conv_fin |=> done_ff) else $error("done not set");     // RULE5
    done_clr_start_a: assert property (@(posedge clock_in) disable iff (!rst_n_ff)
        clk_en_in && acq_end && !conv_fin |=> !done_ff) else $error("done kept"); // RULE7
    sw_no_set_a: assert property (@(posedge clock_in) disable iff (!rst_n_ff)
        clk_en_in && !done_ff && !conv_fin |=> !done_ff) else $error("done set by sw"); // RULE6
    auto_restart_a: assert property (@(posedge clock_in) disable iff (!rst_n_ff)
        clk_en_in && conv_fin && auto_acq && conv_on |=> state_ff == ST_SAMPLE)
        else $error("no auto restart");                                     // RULE1
    soft_end_a: assert property (@(posedge clock_in) disable iff (!rst_n_ff)
        clk_en_in && state_ff == ST_SAMPLE && sw_acq_end && conv_on
        |=> state_ff == ST_CONVERT) else $error("soft end ignored");        // RULE3
    off_idle_a: assert property (@(posedge clock_in) disable iff (!rst_n_ff)
        clk_en_in && !conv_on |=> state_ff == ST_IDLE) else $error("runs while off"); // RULE25
    twelve_count_a: assert property (@(posedge clock_in) disable iff (!rst_n_ff)
        twelve |-> chan_cnt == 2'b00) else $error("count in twelve-bit");    // RULE11
    irq_pulse_a: assert property (@(posedge clock_in) disable iff (!rst_n_ff)
        clk_en_in && seq_last |=> irq_ff && seq_cnt_ff == 4'h0) else $error("irq missed"); // RULE13
    ready_next_a: assert property (@(posedge clock_in) disable iff (!rst_n_ff)
        clk_en_in && bus_setup |=> pready_ff) else $error("late ready");
    cv_convert_c: cover property (@(posedge clock_in) conv_fin);
    cv_irq_c: cover property (@(posedge clock_in) seq_last && split);
    cv_auto_c: cover property (@(posedge clock_in) auto_end);
    cv_alt_c: cover property (@(posedge clock_in) use_b && !scan_unused);
endmodule

`default_nettype wire

// [bench/tb.sv]
`timescale 1ns/10ps
`default_nettype none

module tb;
    import asq_pkg::*;

    // ****************************************************************
    // Stimulus and observed signals
    // ****************************************************************
    logic              clock_in       = 1'b0;
    logic              arst_n_in      = 1'b0;
    logic              psel_in        = 1'b0;
    logic              penable_in     = 1'b0;
    logic              pwrite_in      = 1'b0;
    logic              rc_tick_in     = 1'b0;
    logic [7:0]        paddr_in       = 8'h00;
    logic [31:0]       pwdata_in      = 32'h0000_0000;
    logic [2:0]        ext_trigger_in = 3'h0;
    logic [31:0]       prdata_out;
    logic              pready_out;
    logic              pslverr_out;
    logic              sampling_out;
    logic              convert_out;
    logic              sample_b_out;
    logic              seq_irq_out;
    logic [3:0]        buf_index_out;
    asq_route_t        route_out;
    logic [32:0]       exp_q[$];
    logic              conv_d         = 1'b0;
    logic [31:0]       v;
    logic [7:0]        tbl_addr[4]    = '{OFS_CTRL_TWO, OFS_CTRL_THREE, OFS_AUX_SEL, OFS_LEAD_SEL};
    logic [15:0]       tbl_mask[4]    = '{C2_WMASK, C3_WMASK, AUX_WMASK, LEAD_WMASK};
    int                fail_count     = 0;
    int                n_checks       = 0;
    int                nconv          = 0;
    int                nirq           = 0;
    int                cycles         = 0;
    int                c0;
    int                n0;

    asq_top asq_top_i (.clock_in(clock_in), .arst_n_in(arst_n_in), .clk_en_in(1'b1),
        .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
        .paddr_in(paddr_in), .pwdata_in(pwdata_in), .ext_trigger_in(ext_trigger_in),
        .rc_tick_in(rc_tick_in), .scan_inputs_in(6'h00), .prdata_out(prdata_out),
        .pready_out(pready_out), .pslverr_out(pslverr_out), .sampling_out(sampling_out),
        .convert_out(convert_out), .sample_b_out(sample_b_out),
        .buf_index_out(buf_index_out), .seq_irq_out(seq_irq_out), .route_out(route_out));

    // 200 MHz clock
    always #2.5 clock_in = ~clock_in;

    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // Conversion and interrupt counters, random RC ticks, hang guard
    always @(posedge clock_in)
    begin
        conv_d <= convert_out;
        if (convert_out === 1'b1 && conv_d !== 1'b1)
            nconv <= nconv + 1;
        if (seq_irq_out === 1'b1)
            nirq <= nirq + 1;
        rc_tick_in <= 1'($urandom);
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            fail_count++;
            end_sim;
        end
    end

    // Read monitor: oldest noted result against {pslverr, prdata}
    always @(posedge clock_in)
        if (psel_in && penable_in && !pwrite_in && pready_out === 1'b1)
        begin
            if (exp_q.size() == 0)
                chk(33'h0, 33'h1);
            else
                chk({pslverr_out, prdata_out}, exp_q.pop_front());
        end

    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clock_in);
        psel_in <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clock_in);
        penable_in <= 1'b1;
        k = 0;
        do
        begin
            @(posedge clock_in);
            k++;
        end while (pready_out !== 1'b1 && k < 50);
        if (k == 50)
            chk(33'h0, 33'h1);
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [32:0] exp);
        exp_q.push_back(exp);
        apb(1'b0, a, 32'h0000_0000);
    endtask

    // Bounded waits on the converter state and interrupt count
    task automatic wait_conv(input logic lvl);
        int k;
        k = 0;
        while (convert_out !== lvl && k < 300)
        begin
            @(posedge clock_in);
            k++;
        end
        if (k == 300)
            chk(33'h0, 33'h1);
    endtask

    task automatic wait_irq(input int target);
        int k;
        k = 0;
        while (nirq < target && k < 3000)
        begin
            @(posedge clock_in);
            k++;
        end
        if (k == 3000)
            chk(33'h0, 33'h1);
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        void'($urandom(32'hd71f));
        repeat (20) @(posedge clock_in);
        arst_n_in <= 1'b1;
        repeat (3) @(posedge clock_in);
        for (int i = 0; i < 6; i++)
            rd(8'(4 * i), 33'h0_0000_0000);
        rd(8'h18, 33'h1_0000_0000);
        // Random values through each plain register; unimplemented bits read zero
        for (int i = 0; i < 4; i++)
        begin
            v = $urandom;
            wr(tbl_addr[i], v);
            rd(tbl_addr[i], {17'h0_0000, v[15:0] & tbl_mask[i]});
            if (i == 0)
                chk(33'(route_out.reference), 33'(v[15:13]));
        end
        wr(OFS_CTRL_TWO, 32'h0000_0000);
        wr(OFS_CTRL_THREE, 32'h0000_0000);
        // Twelve-bit mode, set while off, hides the channel count
        wr(OFS_CTRL_ONE, 32'h0000_0400);
        wr(OFS_CTRL_TWO, 32'h0000_0300);
        rd(OFS_CTRL_TWO, 33'h0_0000_0000);
        wr(OFS_CTRL_ONE, 32'h0000_0000);
        wr(OFS_CTRL_TWO, 32'h0000_0000);
        // Software-timed conversion, then done clear and ignored set
        wr(OFS_CTRL_ONE, 32'h0000_8000);
        wr(OFS_CTRL_ONE, 32'h0000_8002);
        rd(OFS_CTRL_ONE, 33'h0_0000_8002);
        chk(33'(sampling_out), 33'd1);
        n0 = nirq;
        wr(OFS_CTRL_ONE, 32'h0000_8000);
        rd(OFS_CTRL_ONE, 33'h0_0000_8000);
        wait_conv(1'b1);
        wait_conv(1'b0);
        rd(OFS_CTRL_ONE, 33'h0_0000_8001);
        chk(33'({sampling_out, convert_out}), 33'd0);
        chk(33'(nirq - n0), 33'd1);
        wr(OFS_CTRL_ONE, 32'h0000_8000);
        rd(OFS_CTRL_ONE, 33'h0_0000_8000);
        wr(OFS_CTRL_ONE, 32'h0000_8001);
        rd(OFS_CTRL_ONE, 33'h0_0000_8000);
        // External trigger codes 001, 010, 011 and 101; done from the last run must drop
        foreach (tbl_addr[i])
        begin
            n0 = (i == 3) ? 5 : i + 1;
            wr(OFS_CTRL_ONE, 32'h0000_8003 | 32'(n0 << 5));
            @(posedge clock_in);
            ext_trigger_in <= 3'(1 << ((n0 - 1) % 4));
            repeat (3) @(posedge clock_in);
            ext_trigger_in <= 3'h0;
            wait_conv(1'b1);
            rd(OFS_CTRL_ONE, 33'(32'h0000_8000 | 32'(n0 << 5)));
            wait_conv(1'b0);
        end
        // Free run: auto start, counter trigger, RC ticks, every third sequence,
        // split halves, two channels, alternating A/B selects
        wr(OFS_CTRL_THREE, 32'h0000_8300);
        wr(OFS_LEAD_SEL, 32'h0000_0A03);
        wr(OFS_CTRL_TWO, 32'h0000_010B);
        n0 = nirq;
        c0 = nconv;
        wr(OFS_CTRL_ONE, 32'h0000_80E4);
        wait_irq(n0 + 1);
        chk(33'(nconv - c0), 33'd3);
        chk(33'({buf_index_out, sample_b_out, route_out.lead_pos}), 33'h22A);
        rd(OFS_CTRL_TWO, 33'h0_0000_018B);
        wait_irq(n0 + 2);
        chk(33'(nconv - c0), 33'd6);
        chk(33'({buf_index_out, sample_b_out, route_out.lead_pos}), 33'h003);
        rd(OFS_CTRL_TWO, 33'h0_0000_010B);
        // Switching off stops new conversions
        wr(OFS_CTRL_ONE, 32'h0000_0000);
        repeat (40) @(posedge clock_in);
        c0 = nconv;
        repeat (200) @(posedge clock_in);
        chk(33'(nconv - c0), 33'd0);
        end_sim;
    end
endmodule

`default_nettype wire
